// ---- rtl/mwc_map.svh ----
// register indexes, field positions, reset values and wait counts of the wait-state block
`ifndef MWC_MAP_SVH
`define MWC_MAP_SVH
`define MWC_IDX_MEM_WAIT   7'h62
`define MWC_IDX_MISC_WAIT  7'h63
`define MWC_IDX_ROM_CFG    7'h65
`define MWC_IDX_STATUS     7'h6F
`define MWC_RST_REG        8'h00
`define MWC_B_DOS_WE       6
`define MWC_B_ROM_WE       5
`define MWC_B_MISS_TO      4
`define MWC_B_WIDE_MEM     2
`define MWC_B_NARROW_MEM   0
`define MWC_B_MGMT_SIZE    7
`define MWC_B_BANK_MISS    6
`define MWC_B_FC_HI        5
`define MWC_B_FC_LO        4
`define MWC_B_CORE_IO      3
`define MWC_B_WIDE_IO      2
`define MWC_B_SHUTDOWN_CYCLE_LENGTH        0
`define MWC_B_PAGE_FIRST_CYCLE_SELECT         5
`define MWC_NARROW_BASE    3'h5
`define MWC_WIDE_BASE      3'h4
`define MWC_WAIT_0         3'h0
`define MWC_WAIT_1         3'h1
`define MWC_WAIT_2         3'h2
`define MWC_WAIT_3         3'h3
`define MWC_WAIT_4         3'h4
`define MWC_WAIT_5         3'h5
`define MWC_SHUT_SHORT     6'h10
`define MWC_SHUT_LONG      6'h20
`define MWC_MGMT_BASE      20'h60000
`define MWC_MGMT_MASK_16K  20'h03FFF
`define MWC_MGMT_MASK_64K  20'h0FFFF
`define MWC_SRAM_MODE_FAST 2'h0
`define MWC_SRAM_MODE_SLOW 2'h1
`define MWC_RD_ZERO        32'h0000_0000
`endif

// ---- rtl/mwc_pkg.sv ----
// types shared by the wait-state configuration block
package mwc_pkg;
  typedef logic [2:0] mwc_wait_t;
  typedef enum logic {MWC_BUS_IDLE, MWC_BUS_ANSWER} mwc_bus_state_t;
endpackage : mwc_pkg

// ---- rtl/mwc_cfg_reg.sv ----
// one byte-wide configuration register with synchronous reset
`timescale 1ns/1ps
`default_nettype none
module mwc_cfg_reg #(
  parameter logic [7:0] RESET = 8'h00
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // write port
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  // stored value
  output logic      [7:0] q_o
);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q_o <= RESET;
    end else if (wr_en_i) begin
      q_o <= wr_data_i;
    end
  end
endmodule : mwc_cfg_reg
`default_nettype wire

// ---- rtl/mwc_wait_config.sv ----
// wait-state configuration registers with decoded wait counts for the sequencers
// What this block does
// [R1] memory wait bit 6 set allows writes to the dos chip-select region
// [R2] memory wait bit 5 set allows writes to the rom chip-select region
// [R3] software sets the page-miss timeout bit for 33 MHz operation
// [R4] 8-bit isa memory field 00..11 gives 5, 4, 3, 2 clock delays
// [R5] 8-bit setting also covers mapped rom bios cycles without 16-bit select
// [R6] 16-bit isa memory field 00..11 gives 4, 3, 2, 1 clock delays
// [R7] 16-bit setting applies on 16-bit select or 16-bit dos or card regions
// [R8] control bit 7 picks management page size: 16 Kbyte or 64 Kbyte
// [R9] on management interrupt a page of that size maps at 60000h
// [R10] internal core io uses 4 waits, or 2 when bit 3 set
// [R11] 16-bit io including card cycles uses 4 waits, or 3 when bit 2 set
// [R12] shutdown cycle lasts 16 cycles, or 32 when bit 0 set
// [R13] software sets control bits 5 and 6 for 33 MHz operation
// [R14] dram first cycle: select 0 uses lo bit (1/2), select 1 uses hi bit (2/3)
// [R15] dram bank miss is 3, or 4/5 by bank-miss bit when timeout bit set
// [R16] sram mode 00 gives 0 read 1 write; mode 01 gives 1/1 or 2/2
// [R17] sram waits act only when the memory type selects sram
// [R18] page first-cycle select is bit 5 of the readable rom config register
// [R19] both wait registers are write-only; reserved bits have no effect
// [R20] both wait registers reset to zero so defaults apply
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "mwc_map.svh"
module mwc_wait_config
  import mwc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [8:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // cycle context from the bus sequencer
  input  wire logic        memcs16_n_i,
  input  wire logic        rom_dos_16_i,
  input  wire logic        pcmcia_16_i,
  input  wire logic        mem_write_i,
  input  wire logic        dos_chip_select_i,
  input  wire logic        rom_chip_select_i,
  input  wire logic        smi_i,
  input  wire logic        sram_select_i,
  input  wire logic [1:0]  mem_mode_i,
  // decoded isa memory waits
  output mwc_wait_t        narrow_isa_mem_wait_o,
  output mwc_wait_t        wide_isa_mem_wait_o,
  output mwc_wait_t        isa_mem_wait_o,
  // region write permission
  output logic             dos_region_write_enable_o,
  output logic             rom_region_write_enable_o,
  output logic             region_write_ok_o,
  // io and shutdown timing
  output mwc_wait_t        internal_core_io_wait_o,
  output mwc_wait_t        wide_io_wait_o,
  output logic      [5:0]  shutdown_cycle_length_o,
  // dram page mode and sram
  output mwc_wait_t        dram_first_wait_o,
  output mwc_wait_t        dram_bank_miss_wait_o,
  output logic             sram_active_o,
  output mwc_wait_t        sram_read_wait_o,
  output mwc_wait_t        sram_write_wait_o,
  // management page mapping
  output logic             mgmt_page_size_o,
  output logic             mgmt_page_active_o,
  output logic      [19:0] mgmt_page_base_o,
  output logic      [19:0] mgmt_page_limit_o
);

  mwc_bus_state_t bus_state;
  mwc_bus_state_t next_bus_state;
  logic [7:0] mem_wait;
  logic [7:0] misc_wait;
  logic [7:0] rom_cfg;

  // bus decode
  wire logic [6:0] bus_index = avs_address_i[8:2];
  wire logic       bus_req   = avs_read_i | avs_write_i;
  wire logic       bus_take  = (bus_state == MWC_BUS_ANSWER) & bus_req;
  wire logic       lane0_wr  = bus_take & avs_write_i & avs_byteenable_i[0];
  wire logic       hit_mem   = bus_index == `MWC_IDX_MEM_WAIT;
  wire logic       hit_misc  = bus_index == `MWC_IDX_MISC_WAIT;
  wire logic       hit_rom   = bus_index == `MWC_IDX_ROM_CFG;
  wire logic       hit_stat  = bus_index == `MWC_IDX_STATUS;

  // a request waits one cycle so that read data is a flop at the accepting edge
  always_comb begin
    case (bus_state)
      MWC_BUS_IDLE:   next_bus_state = bus_req ? MWC_BUS_ANSWER : MWC_BUS_IDLE;
      MWC_BUS_ANSWER: next_bus_state = MWC_BUS_IDLE;
      default:        next_bus_state = MWC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_state         <= MWC_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_state         <= next_bus_state;
      avs_waitrequest_o <= next_bus_state != MWC_BUS_ANSWER;
    end
  end

  // storage: reserved bits of the two wait registers are kept but nothing reads them; rom config reads back whole
  mwc_cfg_reg #(.RESET(`MWC_RST_REG)) u_mem_wait ( // R20
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_en_i   (lane0_wr & hit_mem),
    .wr_data_i (avs_writedata_i[7:0]),
    .q_o       (mem_wait)
  );

  mwc_cfg_reg #(.RESET(`MWC_RST_REG)) u_misc_wait ( // R20
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_en_i   (lane0_wr & hit_misc),
    .wr_data_i (avs_writedata_i[7:0]),
    .q_o       (misc_wait)
  );

  mwc_cfg_reg #(.RESET(`MWC_RST_REG)) u_rom_cfg (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_en_i   (lane0_wr & hit_rom),
    .wr_data_i (avs_writedata_i[7:0]),
    .q_o       (rom_cfg)
  );

  // field decode
  wire logic [1:0] narrow_fld = mem_wait[`MWC_B_NARROW_MEM +: 2];
  wire logic [1:0] wide_fld   = mem_wait[`MWC_B_WIDE_MEM +: 2];
  wire logic       page_first_cycle_select       = rom_cfg[`MWC_B_PAGE_FIRST_CYCLE_SELECT];
  wire mwc_wait_t  narrow_dec = `MWC_NARROW_BASE - {1'b0, narrow_fld}; // R4
  wire mwc_wait_t  wide_dec   = `MWC_WIDE_BASE - {1'b0, wide_fld};     // R6
  // 16-bit select, 16-bit dos or 16-bit card picks the wide count; every
  // other isa memory cycle, mapped rom bios included, takes the narrow one
  wire logic       wide_cycle = ~memcs16_n_i | rom_dos_16_i | pcmcia_16_i; // R7
  wire mwc_wait_t  isa_dec    = wide_cycle ? wide_dec : narrow_dec;         // R5
  wire logic       dos_we     = mem_wait[`MWC_B_DOS_WE]; // R1
  wire logic       rom_we     = mem_wait[`MWC_B_ROM_WE]; // R2
  wire logic       wr_ok      = mem_write_i &
                                ((dos_chip_select_i & dos_we) | (rom_chip_select_i & rom_we));
  wire mwc_wait_t  core_dec   = misc_wait[`MWC_B_CORE_IO] ? `MWC_WAIT_2 : `MWC_WAIT_4; // R10
  wire mwc_wait_t  wio_dec    = misc_wait[`MWC_B_WIDE_IO] ? `MWC_WAIT_3 : `MWC_WAIT_4; // R11
  wire logic [5:0] shut_dec   = misc_wait[`MWC_B_SHUTDOWN_CYCLE_LENGTH] ? `MWC_SHUT_LONG : `MWC_SHUT_SHORT; // R12
  wire mwc_wait_t  fc_lo_dec  = misc_wait[`MWC_B_FC_LO] ? `MWC_WAIT_2 : `MWC_WAIT_1;
  wire mwc_wait_t  fc_hi_dec  = misc_wait[`MWC_B_FC_HI] ? `MWC_WAIT_3 : `MWC_WAIT_2;
  wire mwc_wait_t  fc_dec     = page_first_cycle_select ? fc_hi_dec : fc_lo_dec; // R14 R18
  wire mwc_wait_t  bm_sel     = misc_wait[`MWC_B_BANK_MISS] ? `MWC_WAIT_5 : `MWC_WAIT_4;
  wire mwc_wait_t  bm_dec     = mem_wait[`MWC_B_MISS_TO] ? bm_sel : `MWC_WAIT_3; // R15 R3
  // mode 01 slows sram by the first-cycle lo bit; other modes keep the fast pair
  wire logic       sram_slow  = mem_mode_i == `MWC_SRAM_MODE_SLOW;
  wire mwc_wait_t  sram_rd    = !sram_slow ? `MWC_WAIT_0 :
                                (misc_wait[`MWC_B_FC_LO] ? `MWC_WAIT_2 : `MWC_WAIT_1); // R16
  wire mwc_wait_t  sram_wr    = !sram_slow ? `MWC_WAIT_1 :
                                (misc_wait[`MWC_B_FC_LO] ? `MWC_WAIT_2 : `MWC_WAIT_1); // R16
  wire logic       mgmt_size  = misc_wait[`MWC_B_MGMT_SIZE]; // R8
  wire logic [19:0] mgmt_mask = mgmt_size ? `MWC_MGMT_MASK_64K : `MWC_MGMT_MASK_16K;

  // the wait registers answer reads with zero; only config and status read back
  wire logic [31:0] status_word = {6'h00, shutdown_cycle_length_o, mgmt_page_active_o,
                                   sram_active_o, sram_read_wait_o, sram_write_wait_o,
                                   dram_bank_miss_wait_o, dram_first_wait_o,
                                   wide_io_wait_o, internal_core_io_wait_o};
  wire logic [31:0] rd_mux = hit_rom  ? {24'h00_0000, rom_cfg} : // R18
                             hit_stat ? status_word :
                             `MWC_RD_ZERO;                       // R19

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      avs_readdata_o <= `MWC_RD_ZERO;
    end else if (bus_state == MWC_BUS_IDLE && avs_read_i) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // decoded outputs, registered; reset shows the zero-register defaults
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      narrow_isa_mem_wait_o     <= `MWC_NARROW_BASE;
      wide_isa_mem_wait_o       <= `MWC_WIDE_BASE;
      isa_mem_wait_o            <= `MWC_NARROW_BASE;
      dos_region_write_enable_o <= 1'b0;
      rom_region_write_enable_o <= 1'b0;
      region_write_ok_o         <= 1'b0;
      internal_core_io_wait_o   <= `MWC_WAIT_4;
      wide_io_wait_o            <= `MWC_WAIT_4;
      shutdown_cycle_length_o   <= `MWC_SHUT_SHORT;
      dram_first_wait_o         <= `MWC_WAIT_1;
      dram_bank_miss_wait_o     <= `MWC_WAIT_3;
      sram_active_o             <= 1'b0;
      sram_read_wait_o          <= `MWC_WAIT_0;
      sram_write_wait_o         <= `MWC_WAIT_0;
      mgmt_page_size_o          <= 1'b0;
      mgmt_page_active_o        <= 1'b0;
      mgmt_page_base_o          <= `MWC_MGMT_BASE;
      mgmt_page_limit_o         <= `MWC_MGMT_BASE;
    end else begin
      narrow_isa_mem_wait_o     <= narrow_dec;
      wide_isa_mem_wait_o       <= wide_dec;
      isa_mem_wait_o            <= isa_dec;
      dos_region_write_enable_o <= dos_we;
      rom_region_write_enable_o <= rom_we;
      region_write_ok_o         <= wr_ok;                              // R1 R2
      internal_core_io_wait_o   <= core_dec;
      wide_io_wait_o            <= wio_dec;
      shutdown_cycle_length_o   <= shut_dec;
      dram_first_wait_o         <= fc_dec;
      dram_bank_miss_wait_o     <= bm_dec;
      sram_active_o             <= sram_select_i;                      // R17
      sram_read_wait_o          <= sram_select_i ? sram_rd : `MWC_WAIT_0; // R17
      sram_write_wait_o         <= sram_select_i ? sram_wr : `MWC_WAIT_0; // R17
      mgmt_page_size_o          <= mgmt_size;
      mgmt_page_active_o        <= smi_i;                              // R9
      mgmt_page_base_o          <= `MWC_MGMT_BASE;
      // limit is only meaningful while the page is active
      mgmt_page_limit_o         <= smi_i ? (`MWC_MGMT_BASE | mgmt_mask) : `MWC_MGMT_BASE; // R9
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_mem;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && hit_mem;
  endsequence
  sequence s_wr_misc;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && hit_misc;
  endsequence
  sequence s_rd_rom;
    avs_read_i && avs_waitrequest_o && bus_state == MWC_BUS_IDLE && hit_rom;
  endsequence
  sequence s_rd_wait_reg;
    avs_read_i && avs_waitrequest_o && bus_state == MWC_BUS_IDLE && (hit_mem || hit_misc);
  endsequence

  a_bus_answer_once:
    assert property (bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest did not drop for exactly one cycle");
  a_dos_write_enable: // R1
    assert property (s_wr_mem |-> ##2 dos_region_write_enable_o == $past(avs_writedata_i[6], 2))
    else $error("dos write enable does not follow bit 6");
  a_rom_write_gate: // R2
    assert property (mem_write_i && rom_chip_select_i && !dos_chip_select_i
                     |=> region_write_ok_o == $past(rom_we))
    else $error("rom region write not gated by bit 5");
  a_narrow_isa_wait: // R4
    assert property (s_wr_mem |-> ##2
                     narrow_isa_mem_wait_o == 3'h5 - {1'b0, $past(avs_writedata_i[1:0], 2)})
    else $error("8-bit memory wait decode wrong");
  a_wide_isa_wait: // R6
    assert property (s_wr_mem |-> ##2
                     wide_isa_mem_wait_o == 3'h4 - {1'b0, $past(avs_writedata_i[3:2], 2)})
    else $error("16-bit memory wait decode wrong");
  a_wide_cycle_pick: // R7
    assert property (!memcs16_n_i |=> isa_mem_wait_o == $past(wide_dec))
    else $error("16-bit select did not pick the wide wait");
  a_core_io_wait: // R10
    assert property (s_wr_misc |-> ##2
                     internal_core_io_wait_o == ($past(avs_writedata_i[3], 2) ? 3'h2 : 3'h4))
    else $error("internal core io wait wrong");
  a_wide_io_wait: // R11
    assert property (s_wr_misc |-> ##2
                     wide_io_wait_o == ($past(avs_writedata_i[2], 2) ? 3'h3 : 3'h4))
    else $error("16-bit io wait wrong");
  a_shutdown_length: // R12
    assert property (s_wr_misc |-> ##2
                     shutdown_cycle_length_o == ($past(avs_writedata_i[0], 2) ? 6'h20 : 6'h10))
    else $error("shutdown length wrong");
  a_mgmt_page_map: // R9
    assert property (smi_i |=> mgmt_page_active_o && mgmt_page_limit_o ==
                     ($past(mgmt_size) ? 20'h6FFFF : 20'h63FFF))
    else $error("management page limit wrong");
  a_bank_miss_wait: // R15
    assert property (!mem_wait[`MWC_B_MISS_TO] ##1 !mem_wait[`MWC_B_MISS_TO]
                     |-> dram_bank_miss_wait_o == 3'h3)
    else $error("bank miss default not 3");
  a_sram_gate: // R17
    assert property (!sram_select_i |=> !sram_active_o && sram_read_wait_o == 3'h0)
    else $error("sram waits active without sram select");

  // reset itself is the trigger here, so the default disable is switched off
  a_reset_defaults: // R20
    assert property (@(posedge mclk_i) disable iff (1'b0)
                     rst_i |=> narrow_isa_mem_wait_o == 3'h5 && wide_isa_mem_wait_o == 3'h4 &&
                     dram_first_wait_o == 3'h1 && dram_bank_miss_wait_o == 3'h3 &&
                     shutdown_cycle_length_o == 6'h10 && avs_waitrequest_o &&
                     avs_readdata_o == 32'h0)
    else $error("outputs not at defaults after reset");
  a_dos_write_gate: // R1
    assert property (mem_write_i && dos_chip_select_i && !rom_chip_select_i
                     |=> region_write_ok_o == $past(mem_wait[`MWC_B_DOS_WE]))
    else $error("dos region write not gated by bit 6");
  a_rom_write_enable: // R2
    assert property (s_wr_mem |-> ##2
                     rom_region_write_enable_o == $past(avs_writedata_i[5], 2))
    else $error("rom write enable does not follow bit 5");
  a_narrow_cycle_pick: // R5
    assert property (memcs16_n_i && !rom_dos_16_i && !pcmcia_16_i
                     |=> isa_mem_wait_o == narrow_isa_mem_wait_o)
    else $error("8-bit cycle did not pick the narrow wait");
  a_region_wide_pick: // R7
    assert property (rom_dos_16_i || pcmcia_16_i |=> isa_mem_wait_o == wide_isa_mem_wait_o)
    else $error("16-bit region did not pick the wide wait");
  a_mgmt_size_bit: // R8
    assert property (s_wr_misc |-> ##2 mgmt_page_size_o == $past(avs_writedata_i[7], 2))
    else $error("management page size does not follow bit 7");
  a_mgmt_idle_limit: // R9
    assert property (!smi_i |=> !mgmt_page_active_o && mgmt_page_limit_o == 20'h60000)
    else $error("management page shown without interrupt");
  a_first_cycle_lo: // R14
    assert property (!page_first_cycle_select |=>
                     dram_first_wait_o == ($past(misc_wait[`MWC_B_FC_LO]) ? 3'h2 : 3'h1))
    else $error("first cycle wait wrong with select clear");
  a_first_cycle_hi: // R14 R18
    assert property (page_first_cycle_select |=>
                     dram_first_wait_o == ($past(misc_wait[`MWC_B_FC_HI]) ? 3'h3 : 3'h2))
    else $error("first cycle wait wrong with select set");
  a_bank_miss_timed: // R15
    assert property (mem_wait[`MWC_B_MISS_TO] |=>
                     dram_bank_miss_wait_o == ($past(misc_wait[`MWC_B_BANK_MISS]) ? 3'h5 : 3'h4))
    else $error("bank miss wait wrong with timeout bit set");
  a_sram_fast_mode: // R16
    assert property (sram_select_i && mem_mode_i == 2'h0
                     |=> sram_read_wait_o == 3'h0 && sram_write_wait_o == 3'h1)
    else $error("sram fast mode waits wrong");
  a_sram_slow_mode: // R16
    assert property (sram_select_i && mem_mode_i == 2'h1 |=>
                     sram_read_wait_o == ($past(misc_wait[`MWC_B_FC_LO]) ? 3'h2 : 3'h1) &&
                     sram_write_wait_o == sram_read_wait_o)
    else $error("sram slow mode waits wrong");
  a_rom_cfg_read: // R18
    assert property (s_rd_rom |=> avs_readdata_o == {24'h00_0000, $past(rom_cfg)})
    else $error("rom config read back wrong");
  a_wait_reg_read: // R19
    assert property (s_rd_wait_reg |=> avs_readdata_o == 32'h0)
    else $error("write-only register read not zero");
  a_lane_gate: // R19
    assert property (avs_write_i && !avs_waitrequest_o && !avs_byteenable_i[0]
                     |=> $stable(mem_wait) && $stable(misc_wait))
    else $error("write without byte lane 0 changed a register");
  a_readdata_hold:
    assert property (!(avs_read_i && bus_state == MWC_BUS_IDLE) |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

endmodule : mwc_wait_config
`default_nettype wire

// ---- testbench/tb_mwc_wait_config.sv ----
// self-checking testbench of the wait-state configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_mwc_wait_config;
  import mwc_pkg::*;
  // clock, reset and bus
  logic        mclk_i           = 1'b0;
  logic        rst_i            = 1'b1;
  logic [8:0]  avs_address_i    = 9'h000;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  // cycle context
  logic        memcs16_n_i       = 1'b1;
  logic        rom_dos_16_i      = 1'b0;
  logic        pcmcia_16_i       = 1'b0;
  logic        mem_write_i       = 1'b0;
  logic        dos_chip_select_i = 1'b0;
  logic        rom_chip_select_i = 1'b0;
  logic        smi_i             = 1'b0;
  logic        sram_select_i     = 1'b0;
  logic [1:0]  mem_mode_i        = 2'h0;
  // decoded outputs
  mwc_wait_t   nw, ww, is, cw, wi, fc, bm, srd, swr;
  logic        den, ren, wok, sa, sz, ma;
  logic [5:0]  sh;
  logic [19:0] mb, ml;
  int          fail_count = 0;
  int          num_checks = 0;

  always #10 mclk_i = ~mclk_i;

  mwc_wait_config u_mwc_wait_config (
    .mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .memcs16_n_i, .rom_dos_16_i,
    .pcmcia_16_i, .mem_write_i, .dos_chip_select_i, .rom_chip_select_i, .smi_i,
    .sram_select_i, .mem_mode_i, .narrow_isa_mem_wait_o(nw), .wide_isa_mem_wait_o(ww),
    .isa_mem_wait_o(is), .dos_region_write_enable_o(den), .rom_region_write_enable_o(ren),
    .region_write_ok_o(wok), .internal_core_io_wait_o(cw), .wide_io_wait_o(wi),
    .shutdown_cycle_length_o(sh), .dram_first_wait_o(fc), .dram_bank_miss_wait_o(bm),
    .sram_active_o(sa), .sram_read_wait_o(srd), .sram_write_wait_o(swr),
    .mgmt_page_size_o(sz), .mgmt_page_active_o(ma), .mgmt_page_base_o(mb),
    .mgmt_page_limit_o(ml)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // one avalon transfer, entered just after a rising edge; upper data bits carry junk
  task automatic bus(input logic rd, input logic [6:0] idx, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i    <= {idx, 2'h0};
    avs_read_i       <= rd;
    avs_write_i      <= ~rd;
    avs_writedata_i  <= {24'hFFFFFF, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    chk("answer cycles", 32'h2, 32'(n));
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, idx, d, 4'h1, q);
  endtask : wr

  task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, idx, 8'h00, 4'hF, q);
    chk("readdata", exp, q);
  endtask : rdc

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // mode 01 rows need both values of control bit 4 with sram selected
  logic [7:0] tbl [8] = '{8'h00, 8'hFD, 8'h50, 8'h2C, 8'h81, 8'h6A, 8'hB4, 8'h19};

  initial begin
    logic [7:0] d;
    logic       pf, ms, sl, sm;
    logic [1:0] md;
    mwc_wait_t  sw;
    logic [31:0] q;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(2);
    chk("defaults", {3'h5, 3'h4, 3'h4, 3'h4, 6'h10, 3'h1, 3'h3, 3'h0, 3'h0},
        {nw, ww, cw, wi, sh, fc, bm, srd, swr});
    chk("reset flags", 32'h60000, {den, ren, wok, sz, ma, sa, ml});
    rdc(7'h6F, {6'h00, 6'h10, 1'b0, 1'b0, 3'h0, 3'h0, 3'h3, 3'h1, 3'h4, 3'h4});
    wr(7'h62, 8'h80);
    bus(1'b0, 7'h63, 8'hFF, 4'h0, q);
    wr(7'h10, 8'hFF);
    tick(3);
    chk("reserved", {3'h5, 3'h4, 3'h5, 3'h4, 3'h4, 6'h10}, {nw, ww, is, cw, wi, sh});
    rdc(7'h62, 32'h0);
    rdc(7'h63, 32'h0);
    rdc(7'h10, 32'h0);
    for (int v = 0; v < 4; v++) begin
      wr(7'h62, 8'(v * 5));
      tick(3);
      chk("isa waits", {3'(5 - v), 3'(4 - v)}, {nw, ww});
    end
    for (int k = 0; k < 4; k++) begin
      memcs16_n_i  <= (k != 1);
      rom_dos_16_i <= (k == 2);
      pcmcia_16_i  <= (k == 3);
      tick(3);
      chk("isa select", (k == 0) ? 32'h2 : 32'h1, is);
    end
    for (int m = 0; m < 4; m++) begin
      wr(7'h62, 8'(m << 5));
      for (int c = 0; c < 8; c++) begin
        {mem_write_i, dos_chip_select_i, rom_chip_select_i} <= 3'(c);
        tick(3);
        chk("region", {m[1], m[0], c[2] & (c[1] & m[1] | c[0] & m[0])}, {den, ren, wok});
      end
    end
    for (int i = 0; i < 8; i++) begin
      d  = tbl[i];
      pf = i[0];
      ms = i[1];
      sl = i[2];
      sm = i[0] ^ i[2];
      md = 2'(i % 3);
      wr(7'h65, {2'h0, pf, 5'h0});
      rdc(7'h65, {26'h0, pf, 5'h0});
      wr(7'h62, {3'h0, ms, 4'h0});
      wr(7'h63, d);
      sram_select_i <= sl;
      smi_i         <= sm;
      mem_mode_i    <= md;
      tick(3);
      sw = (md == 2'h1) ? (d[4] ? 3'h2 : 3'h1) : 3'h0;
      chk("io", {d[3] ? 3'h2 : 3'h4, d[2] ? 3'h3 : 3'h4, d[0] ? 6'h20 : 6'h10, d[7]},
          {cw, wi, sh, sz});
      chk("dram", {pf ? (d[5] ? 3'h3 : 3'h2) : (d[4] ? 3'h2 : 3'h1),
          ms ? (d[6] ? 3'h5 : 3'h4) : 3'h3}, {fc, bm});
      chk("sram", {sl, sl ? sw : 3'h0, sl ? ((md == 2'h1) ? sw : 3'h1) : 3'h0},
          {sa, srd, swr});
      chk("mgmt base", 32'h60000, mb);
      chk("mgmt", {sm, sm ? (d[7] ? 20'h6FFFF : 20'h63FFF) : 20'h60000}, {ma, ml});
    end
    complete_run();
  end

  // a hang is cut short well beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    complete_run();
  end
endmodule : tb_mwc_wait_config
`default_nettype wire
